// *** logic/chglim_regs.sv ***
`timescale 1ns/1ns
module chglim_regs (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Decoded word commands from the serial front end
  input  wire chglim_pkg::chglim_cmd_type cmd,
  output wire logic [15:0]                cmd_rdata,
  output wire logic                       cmd_rvalid,
  // Presence pins
  input  wire logic                       adapter_present_pin,
  input  wire logic                       battery_present_pin,
  // Operating state from the charger core
  input  wire logic                       charging,
  input  wire logic                       learn_request,
  input  wire logic                       low_power_mode,
  input  wire logic                       platform_power_monitor_en,
  input  wire logic [1:0]                 cfg_zero_dc_sel,
  input  wire logic [1:0]                 cfg_two_debounce_sel,
  input  wire logic [2:0]                 cfg_two_hold_sel,
  // Measurements, LSB 1 mV or 1 mA
  input  wire logic [15:0]                battery_voltage_mv,
  input  wire logic [15:0]                adapter_current_ma,
  input  wire logic [15:0]                discharge_current_ma,
  // Regulation targets and modes
  output wire logic [15:0]                charge_voltage_limit,
  output wire logic [15:0]                regulation_target,
  output wire logic [2:0]                 first_limit_duration,
  output wire logic [2:0]                 second_limit_duration,
  output wire logic [7:0]                 first_limit_time_100us,
  output wire logic [13:0]                second_limit_time_us,
  output wire logic                       trickle_mode,
  output wire logic                       learn_mode,
  output wire logic                       comparator_reference_active,
  // Open-drain processor-hot pin
  input  wire logic                       processor_hot_in,
  output wire logic                       processor_hot_out,
  output wire logic                       processor_hot_oe_n
);

  chglim_pkg::chglim_regs_type r;
  chglim_pkg::chglim_regs_type next_r;
  logic [1:0]  present;
  logic        adapter_present;
  logic        battery_present;
  logic        alert;
  logic [15:0] dc_limit;
  logic [7:0]  first_time;
  logic [13:0] second_time;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Keep only the valid bits, then pull an oversized value down to its maximum
  function automatic logic [15:0] mask_clamp(input logic [15:0] data,
                                             input logic [15:0] mask,
                                             input logic [15:0] max);
    logic [15:0] kept;
    kept = data & mask;
    return (kept > max) ? max : kept;
  endfunction

  // Register contents seen by a read; unmapped codes read zero
  function automatic logic [15:0] read_word(input logic [7:0] code,
                                            input chglim_pkg::chglim_regs_type cur);
    logic [15:0] word;
    word = 16'h0000;
    case (code)
      chglim_pkg::OFS_CEILING:  word = cur.ceiling;
      chglim_pkg::OFS_DURATION: word = cur.duration;
      chglim_pkg::OFS_FLOOR:    word = cur.floor;
      chglim_pkg::OFS_AC_THR:   word = cur.ac_thr;
      chglim_pkg::OFS_DC_THR:   word = cur.dc_thr;
      chglim_pkg::OFS_INFO:     word[chglim_pkg::INFO_REF_BIT] = cur.ref_active;
      default:                  word = 16'h0000;
    endcase
    return word;
  endfunction

  // ----------------------------------------------------------------------
  // Presence pins
  // ----------------------------------------------------------------------
  chglim_sync u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_in    ({battery_present_pin, adapter_present_pin}),
    .level_out (present)
  );

  assign adapter_present = present[0];
  assign battery_present = present[1];

  // ----------------------------------------------------------------------
  // Register writes, reads and monitors
  // ----------------------------------------------------------------------
  // Discharge limit source follows the supply mode
  always_comb begin
    if (!adapter_present && low_power_mode) begin
      dc_limit = chglim_pkg::LP_DC_THR[cfg_zero_dc_sel];
    end else begin
      dc_limit = r.dc_thr;
    end
  end

  always_comb begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    if (cmd.write) begin
      case (cmd.code)
        chglim_pkg::OFS_CEILING: begin
          next_r.ceiling = mask_clamp(cmd.wdata, chglim_pkg::VOLT_MASK,
                                      chglim_pkg::VOLT_MAX);
        end
        chglim_pkg::OFS_DURATION: begin
          next_r.duration = cmd.wdata & chglim_pkg::DURATION_MASK;
        end
        chglim_pkg::OFS_FLOOR: begin
          next_r.floor = mask_clamp(cmd.wdata, chglim_pkg::VOLT_MASK,
                                    chglim_pkg::VOLT_MAX);
        end
        chglim_pkg::OFS_AC_THR: begin
          next_r.ac_thr = mask_clamp(cmd.wdata, chglim_pkg::AC_MASK,
                                     chglim_pkg::AC_MAX);
        end
        chglim_pkg::OFS_DC_THR: begin
          next_r.dc_thr = mask_clamp(cmd.wdata, chglim_pkg::DC_MASK,
                                     chglim_pkg::DC_MAX);
        end
        default: begin
          next_r.rvalid = 1'b0;
        end
      endcase
    end
    // A read in the same cycle as a write returns the older content
    if (cmd.read) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = read_word(cmd.code, r);
    end
    // Floor is not checked against the ceiling; software keeps it below
    next_r.trickle = battery_present && charging
                     && (battery_voltage_mv < r.floor);
    next_r.learn   = battery_present && learn_request
                     && (battery_voltage_mv >= r.floor);
    // Reference runs with an adapter, else only with the power monitor on
    next_r.ref_active = adapter_present || platform_power_monitor_en;
    next_r.ac_over    = adapter_present && (adapter_current_ma > r.ac_thr);
    next_r.dc_over    = next_r.ref_active && (discharge_current_ma > dc_limit);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r            <= '0;
      r.ceiling    <= chglim_pkg::RST_CEILING;
      r.duration   <= chglim_pkg::RST_DURATION;
      r.floor      <= chglim_pkg::RST_FLOOR;
      r.ac_thr     <= chglim_pkg::RST_AC_THR;
      r.dc_thr     <= chglim_pkg::RST_DC_THR;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // Limit duration decode
  // ----------------------------------------------------------------------
  always_comb begin
    case (r.duration[chglim_pkg::FIRST_LSB +: 3])
      3'h0:    first_time = 8'h64;
      3'h1:    first_time = 8'hc8;
      3'h2:    first_time = 8'h96;
      3'h3:    first_time = 8'h32;
      3'h4:    first_time = 8'h0a;
      3'h5:    first_time = 8'h05;
      3'h6:    first_time = 8'h01;
      default: first_time = 8'h00;
    endcase
  end

  always_comb begin
    case (r.duration[chglim_pkg::SECOND_LSB +: 3])
      3'h0:    second_time = 14'h000a;
      3'h1:    second_time = 14'h0064;
      3'h2:    second_time = 14'h01f4;
      3'h3:    second_time = 14'h03e8;
      3'h4:    second_time = 14'h012c;
      3'h5:    second_time = 14'h02ee;
      3'h6:    second_time = 14'h07d0;
      default: second_time = 14'h2710;
    endcase
  end

  // ----------------------------------------------------------------------
  // Processor-hot alert
  // ----------------------------------------------------------------------
  // One timer serves both sources, so either keeps the other's hold alive
  chglim_alert_timer u_alert (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .over         (r.ac_over | r.dc_over),
    .debounce_sel (cfg_two_debounce_sel),
    .hold_sel     (cfg_two_hold_sel),
    .alert        (alert)
  );

  // Pin is shared open-drain; the input is not needed by this logic
  assign processor_hot_out  = 1'b0;
  assign processor_hot_oe_n = ~alert;

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign cmd_rdata                   = r.rdata;
  assign cmd_rvalid                  = r.rvalid;
  assign charge_voltage_limit        = r.ceiling;
  assign regulation_target           = r.trickle ? r.floor : r.ceiling;
  assign first_limit_duration        = r.duration[chglim_pkg::FIRST_LSB +: 3];
  assign second_limit_duration       = r.duration[chglim_pkg::SECOND_LSB +: 3];
  assign first_limit_time_100us      = first_time;
  assign second_limit_time_us        = second_time;
  assign trickle_mode                = r.trickle;
  assign learn_mode                  = r.learn;
  assign comparator_reference_active = r.ref_active;

endmodule // chglim_regs

// *** common/chglim_pkg.sv ***
package chglim_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CNT_W      = 12;

  // Alert debounce and least hold times, in microseconds
  localparam int unsigned DEBOUNCE_US [4] = '{10, 20, 50, 100};
  localparam int unsigned HOLD_US     [8] = '{10, 20, 50, 100, 150, 200, 300, 400};

  // Whole microseconds give exact cycle counts, so no rounding is needed
  function automatic logic [CNT_W-1:0] us_to_cyc(input int unsigned us);
    return CNT_W'(us * CYC_PER_US);
  endfunction

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CEILING  = 8'h15;
  localparam logic [7:0] OFS_DURATION = 8'h38;
  localparam logic [7:0] OFS_INFO     = 8'h3a;
  localparam logic [7:0] OFS_FLOOR    = 8'h3e;
  localparam logic [7:0] OFS_AC_THR   = 8'h47;
  localparam logic [7:0] OFS_DC_THR   = 8'h48;

  // ----------------------------------------------------------------------
  // Field layouts, limits and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] DURATION_MASK = 16'h0707;
  localparam int unsigned FIRST_LSB     = 0;
  localparam int unsigned SECOND_LSB    = 8;
  localparam logic [15:0] VOLT_MASK     = 16'h3ff8;
  localparam logic [15:0] VOLT_MAX      = 16'h3600;
  localparam logic [15:0] AC_MASK       = 16'h1f80;
  localparam logic [15:0] AC_MAX        = 16'h1900;
  localparam logic [15:0] DC_MASK       = 16'h3f00;
  localparam logic [15:0] DC_MAX        = 16'h3200;
  localparam int unsigned INFO_REF_BIT  = 15;

  localparam logic [15:0] RST_CEILING   = 16'h3600;
  localparam logic [15:0] RST_DURATION  = 16'h0000;
  localparam logic [15:0] RST_FLOOR     = 16'h0000;
  localparam logic [15:0] RST_AC_THR    = 16'h0c00;
  localparam logic [15:0] RST_DC_THR    = 16'h1000;

  // Discharge thresholds in battery-only low power mode, in mA
  localparam logic [15:0] LP_DC_THR [4] = '{16'h2ee0, 16'h2710, 16'h1f40, 16'h1770};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CHGLIM_IDLE     = 3'b001,
    CHGLIM_DEBOUNCE = 3'b010,
    CHGLIM_ASSERT   = 3'b100
  } chglim_alert_state_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  code;
    logic [15:0] wdata;
  } chglim_cmd_type;

  typedef struct packed {
    logic [15:0] ceiling;
    logic [15:0] duration;
    logic [15:0] floor;
    logic [15:0] ac_thr;
    logic [15:0] dc_thr;
    logic [15:0] rdata;
    logic        rvalid;
    logic        trickle;
    logic        learn;
    logic        ac_over;
    logic        dc_over;
    logic        ref_active;
  } chglim_regs_type;

  typedef struct packed {
    chglim_alert_state_type state;
    logic [CNT_W-1:0]       count;
  } chglim_timer_type;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] q;
  } chglim_sync_type;

endpackage

// *** logic/chglim_sync.sv ***
`timescale 1ns/1ns
module chglim_sync (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Pins and their filtered levels
  input  wire logic [1:0] pin_in,
  output wire logic [1:0] level_out
);

  chglim_pkg::chglim_sync_type s;
  chglim_pkg::chglim_sync_type next_s;

  // ----------------------------------------------------------------------
  // Three-stage capture; a level is taken once stages two and three agree
  // ----------------------------------------------------------------------
  always_comb begin
    next_s    = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < 2; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_out = s.q;

endmodule // chglim_sync

// *** logic/chglim_alert_timer.sv ***
`timescale 1ns/1ns
module chglim_alert_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Condition and timing selects
  input  wire logic       over,
  input  wire logic [1:0] debounce_sel,
  input  wire logic [2:0] hold_sel,
  // Alert level
  output wire logic       alert
);

  chglim_pkg::chglim_timer_type t;
  chglim_pkg::chglim_timer_type next_t;
  logic [chglim_pkg::CNT_W-1:0] deb_cyc;
  logic [chglim_pkg::CNT_W-1:0] hold_cyc;

  assign deb_cyc  = chglim_pkg::us_to_cyc(chglim_pkg::DEBOUNCE_US[debounce_sel]);
  assign hold_cyc = chglim_pkg::us_to_cyc(chglim_pkg::HOLD_US[hold_sel]);

  // ----------------------------------------------------------------------
  // Debounce, then latch on for at least the hold time
  // ----------------------------------------------------------------------
  always_comb begin
    next_t = t;
    case (t.state)
      chglim_pkg::CHGLIM_IDLE: begin
        next_t.count = '0;
        if (over) begin
          next_t.state = chglim_pkg::CHGLIM_DEBOUNCE;
        end
      end
      chglim_pkg::CHGLIM_DEBOUNCE: begin
        // A glitch shorter than the debounce restarts from idle
        if (!over) begin
          next_t.state = chglim_pkg::CHGLIM_IDLE;
          next_t.count = '0;
        end else if (t.count >= deb_cyc - 1'b1) begin
          next_t.state = chglim_pkg::CHGLIM_ASSERT;
          next_t.count = '0;
        end else begin
          next_t.count = t.count + 1'b1;
        end
      end
      chglim_pkg::CHGLIM_ASSERT: begin
        if (t.count < hold_cyc - 1'b1) begin
          next_t.count = t.count + 1'b1;
        end else if (!over) begin
          next_t.state = chglim_pkg::CHGLIM_IDLE;
          next_t.count = '0;
        end
      end
      default: begin
        next_t.state = chglim_pkg::CHGLIM_IDLE;
        next_t.count = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      t.state <= chglim_pkg::CHGLIM_IDLE;
      t.count <= '0;
    end else begin
      t <= next_t;
    end
  end

  assign alert = (t.state == chglim_pkg::CHGLIM_ASSERT);

endmodule // chglim_alert_timer

// *** dv/chglim_regs_properties.sv ***
`timescale 1ns/1ns
module chglim_regs_properties (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // Register commands
  input wire chglim_pkg::chglim_cmd_type cmd,
  input wire logic [15:0]                cmd_rdata,
  input wire logic                       cmd_rvalid,
  // Targets and modes
  input wire logic [15:0]                charge_voltage_limit,
  input wire logic [15:0]                regulation_target,
  input wire logic                       trickle_mode,
  input wire logic                       comparator_reference_active,
  // Alert pin
  input wire logic                       processor_hot_out,
  input wire logic                       processor_hot_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Register answers
  // ----------------------------------------------------------------------
  property field_p(logic [7:0] c, logic [15:0] m, logic [15:0] mx);
    cmd.read && cmd.code == c |=> (cmd_rdata & ~m) == 16'h0000 && cmd_rdata <= mx;
  endproperty

  read_answer_a : assert property (cmd.read |=> cmd_rvalid)
    else $error("read not answered");
  answer_cause_a : assert property (cmd_rvalid |-> $past(cmd.read))
    else $error("answer without read");
  duration_field_a : assert property (
    field_p(chglim_pkg::OFS_DURATION, chglim_pkg::DURATION_MASK, 16'hffff))
    else $error("duration spare bits set");
  ceiling_field_a : assert property (
    field_p(chglim_pkg::OFS_CEILING, chglim_pkg::VOLT_MASK, chglim_pkg::VOLT_MAX))
    else $error("ceiling out of range");
  floor_field_a : assert property (
    field_p(chglim_pkg::OFS_FLOOR, chglim_pkg::VOLT_MASK, chglim_pkg::VOLT_MAX))
    else $error("floor out of range");
  ac_field_a : assert property (
    field_p(chglim_pkg::OFS_AC_THR, chglim_pkg::AC_MASK, chglim_pkg::AC_MAX))
    else $error("adapter threshold out of range");
  dc_field_a : assert property (
    field_p(chglim_pkg::OFS_DC_THR, chglim_pkg::DC_MASK, chglim_pkg::DC_MAX))
    else $error("discharge threshold out of range");
  info_bit_a : assert property (
    cmd.read && cmd.code == chglim_pkg::OFS_INFO
    |=> cmd_rdata == {$past(comparator_reference_active), 15'h0000})
    else $error("information word wrong");

  // ----------------------------------------------------------------------
  // Targets and alert
  // ----------------------------------------------------------------------
  idle_target_a : assert property (
    !trickle_mode |-> regulation_target == charge_voltage_limit)
    else $error("idle target is not the ceiling");
  // Open drain: the pin may only ever be pulled low
  pin_drive_a : assert property (processor_hot_out == 1'b0)
    else $error("alert pin driven high");
  // Shortest debounce is 100 cycles, so the pin was released that long ago
  alert_debounce_a : assert property (
    $fell(processor_hot_oe_n) |-> $past(processor_hot_oe_n, 100))
    else $error("alert without debounce");
  alert_hold_a : assert property (
    $rose(processor_hot_oe_n) |-> !$past(processor_hot_oe_n, 100))
    else $error("alert released too early");

  cover property ($fell(processor_hot_oe_n));
  cover property ($rose(trickle_mode));
  cover property (cmd.read && cmd.code == chglim_pkg::OFS_INFO ##1 cmd_rdata[15]);
endmodule // chglim_regs_properties

// *** dv/chglim_host_model.sv ***
`timescale 1ns/1ns
module chglim_host_model (
  // Clock
  input wire logic                  ref_clk,
  // Register commands
  output chglim_pkg::chglim_cmd_type cmd,
  input wire logic [15:0]           cmd_rdata,
  input wire logic                  cmd_rvalid
);
  initial cmd = '0;

  // ----------------------------------------------------------------------
  // Word commands
  // ----------------------------------------------------------------------
  // Idle fields carry the inverse so a stale value never reads as valid
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge ref_clk);
    cmd = '{write: 1'b1, read: 1'b0, code: code, wdata: data};
    @(negedge ref_clk);
    cmd = '{write: 1'b0, read: 1'b0, code: ~code, wdata: ~data};
  endtask

  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic valid);
    @(negedge ref_clk);
    cmd = '{write: 1'b0, read: 1'b1, code: code, wdata: ~cmd.wdata};
    @(negedge ref_clk);
    cmd = '{write: 1'b0, read: 1'b0, code: ~code, wdata: ~cmd.wdata};
    data = cmd_rdata;
    valid = cmd_rvalid;
  endtask
endmodule // chglim_host_model

// *** dv/chglim_regs_tb_top.sv ***
`timescale 1ns/1ns
module chglim_regs_tb_top;
  logic                       ref_clk = 1'b0;
  logic                       rst = 1'b1;
  chglim_pkg::chglim_cmd_type cmd;
  logic [15:0]                cmd_rdata, charge_voltage_limit, regulation_target;
  logic                       cmd_rvalid, trickle_mode, learn_mode;
  logic                       comparator_reference_active;
  logic                       adapter_present_pin = 1'b0, battery_present_pin = 1'b0;
  logic                       charging = 1'b0, learn_request = 1'b0;
  logic                       low_power_mode = 1'b0, platform_power_monitor_en = 1'b0;
  logic [1:0]                 cfg_zero_dc_sel = 2'h0, cfg_two_debounce_sel = 2'h0;
  logic [2:0]                 cfg_two_hold_sel = 3'h0;
  logic [15:0]                battery_voltage_mv = 16'h0000;
  logic [15:0]                adapter_current_ma = 16'h0000, discharge_current_ma = 16'h0000;
  logic [2:0]                 first_limit_duration, second_limit_duration;
  logic [7:0]                 first_limit_time_100us;
  logic [13:0]                second_limit_time_us;
  logic                       processor_hot_out, processor_hot_oe_n;
  wire                        processor_hot_in;
  int                         bad_count = 0;
  int                         n_compared = 0;
  int                         cycles = 0;
  logic [7:0]                 codes [5] = '{8'h15, 8'h38, 8'h3e, 8'h47, 8'h48};
  logic [15:0]                big [5] = '{16'h3600, 16'h0707, 16'h3600, 16'h1900, 16'h3200};
  logic [15:0]                odd_w [5] = '{16'h1fff, 16'hf2f5, 16'hc00f, 16'h0c81, 16'h10ff};
  logic [15:0]                odd_e [5] = '{16'h1ff8, 16'h0205, 16'h0008, 16'h0c80, 16'h1000};
  logic [7:0]                 t1 [8] = '{8'h64, 8'hc8, 8'h96, 8'h32, 8'h0a, 8'h05, 8'h01, 8'h00};
  logic [13:0]                t2 [8] = '{14'h000a, 14'h0064, 14'h01f4, 14'h03e8,
                                         14'h012c, 14'h02ee, 14'h07d0, 14'h2710};

  // Pull-up on the open-drain alert line
  assign processor_hot_in = processor_hot_oe_n ? 1'b1 : processor_hot_out;
  always #50 ref_clk = ~ref_clk;

  chglim_regs i_dut (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .adapter_present_pin(adapter_present_pin),
    .battery_present_pin(battery_present_pin), .charging(charging),
    .learn_request(learn_request), .low_power_mode(low_power_mode),
    .platform_power_monitor_en(platform_power_monitor_en), .cfg_zero_dc_sel(cfg_zero_dc_sel),
    .cfg_two_debounce_sel(cfg_two_debounce_sel), .cfg_two_hold_sel(cfg_two_hold_sel),
    .battery_voltage_mv(battery_voltage_mv), .adapter_current_ma(adapter_current_ma),
    .discharge_current_ma(discharge_current_ma), .charge_voltage_limit(charge_voltage_limit),
    .regulation_target(regulation_target), .first_limit_duration(first_limit_duration),
    .second_limit_duration(second_limit_duration),
    .first_limit_time_100us(first_limit_time_100us),
    .second_limit_time_us(second_limit_time_us), .trickle_mode(trickle_mode),
    .learn_mode(learn_mode), .comparator_reference_active(comparator_reference_active),
    .processor_hot_in(processor_hot_in), .processor_hot_out(processor_hot_out),
    .processor_hot_oe_n(processor_hot_oe_n));

  chglim_host_model i_host (.ref_clk(ref_clk), .cmd(cmd), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid));

  // ----------------------------------------------------------------------
  // Shared checks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic rd_check(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    i_host.rd(code, d, v);
    check({15'h0000, v}, 16'h0001, "read answer");
    check(d, exp, "read data");
  endtask

  // Waits for an alert level and judges the delay
  task automatic wait_alert(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (processor_hot_oe_n !== lvl && n < hi) begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(n >= lo && processor_hot_oe_n === lvl), 16'h0001, "alert timing");
  endtask

  task automatic quiet(input int n);
    repeat (n) @(negedge ref_clk);
    check({15'h0000, processor_hot_oe_n}, 16'h0001, "alert stays off");
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd_check(8'h15, 16'h3600);
    rd_check(8'h38, 16'h0000);
    check(16'(second_limit_time_us), 16'h000a, "default second time");
    rd_check(8'h3e, 16'h0000);
    rd_check(8'h47, 16'h0c00);
    rd_check(8'h48, 16'h1000);
    rd_check(8'h20, 16'h0000);
    $display("reset values done");
  endtask

  task automatic t_fields();
    for (int i = 0; i < 5; i++) begin
      i_host.wr(codes[i], 16'hffff);
      rd_check(codes[i], big[i]);
      i_host.wr(codes[i], odd_w[i]);
      rd_check(codes[i], odd_e[i]);
    end
    i_host.wr(8'h3a, 16'hffff);
    rd_check(8'h3a, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      i_host.wr(8'h38, {5'h1f, 3'(7 - i), 5'h1f, 3'(i)});
      check(16'(first_limit_duration), 16'(i), "first code");
      check(16'(first_limit_time_100us), 16'(t1[i]), "first time");
      check(16'(second_limit_duration), 16'(7 - i), "second code");
      check(16'(second_limit_time_us), 16'(t2[7 - i]), "second time");
    end
    $display("fields done");
  endtask

  task automatic t_modes();
    i_host.wr(8'h3e, 16'h1000);
    @(negedge ref_clk);
    battery_present_pin = 1'b1;
    charging = 1'b1;
    battery_voltage_mv = 16'h0fff;
    repeat (6) @(negedge ref_clk);
    check({15'h0000, trickle_mode}, 16'h0001, "trickle entry");
    check(regulation_target, 16'h1000, "trickle target");
    battery_voltage_mv = 16'h1000;
    learn_request = 1'b1;
    @(negedge ref_clk);
    check({15'h0000, trickle_mode}, 16'h0000, "trickle exit");
    check({15'h0000, learn_mode}, 16'h0001, "learn entry");
    check(regulation_target, 16'h1ff8, "idle target");
    check(charge_voltage_limit, 16'h1ff8, "charge limit");
    battery_voltage_mv = 16'h0fff;
    @(negedge ref_clk);
    check({15'h0000, learn_mode}, 16'h0000, "learn exit");
    $display("modes done");
  endtask

  task automatic t_adapter();
    adapter_present_pin = 1'b1;
    adapter_current_ma = 16'h0c80;
    quiet(150);
    rd_check(8'h3a, 16'h8000);
    adapter_current_ma = 16'h0c81;
    wait_alert(1'b0, 98, 106);
    adapter_current_ma = 16'h0000;
    wait_alert(1'b1, 95, 106);
    $display("adapter alert done");
  endtask

  task automatic t_discharge();
    adapter_present_pin = 1'b0;
    low_power_mode = 1'b1;
    cfg_zero_dc_sel = 2'h3;
    cfg_two_debounce_sel = 2'h1;
    cfg_two_hold_sel = 3'h1;
    platform_power_monitor_en = 1'b1;
    discharge_current_ma = 16'h1388;
    quiet(250);
    discharge_current_ma = 16'h1771;
    wait_alert(1'b0, 198, 208);
    discharge_current_ma = 16'h0000;
    wait_alert(1'b1, 195, 206);
    platform_power_monitor_en = 1'b0;
    discharge_current_ma = 16'h2328;
    quiet(250);
    rd_check(8'h3a, 16'h0000);
    $display("discharge alert done");
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_fields();
    t_modes();
    t_adapter();
    t_discharge();
    complete_run();
  end
endmodule // chglim_regs_tb_top

bind chglim_regs chglim_regs_properties i_props (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
  .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .charge_voltage_limit(charge_voltage_limit),
  .regulation_target(regulation_target), .trickle_mode(trickle_mode),
  .comparator_reference_active(comparator_reference_active),
  .processor_hot_out(processor_hot_out), .processor_hot_oe_n(processor_hot_oe_n));
